// File: hdl/icmc_mode_ctrl.v
// Purpose: Mode, channel sequencing and register access of the converter.
// Assumes: SCL, SDA and pins are synchronous to core_clk; SDA is open drain.
// Notes:   The front end supplies results and error levels.
// Overview of operation
// [R1] Single mode repeats one channel; multi scans.
// [R2] Interrupt after conversion or after full scan.
// [R3] Per-channel 16-bit count sets conversion interval.
// [R4] Per-channel settle count sets startup wait.
// [R5] Per-channel reference and sensor dividers.
// [R6] Reference from internal oscillator or external clock.
// [R7] Per-channel drive code, or automatic drive.
// [R8] Report amplitude, oscillation, new data, errors.
// [R9] Power-up in Sleep until sleep bit cleared.
// [R10] Sleep bit one sleeps, zero converts.
// [R11] Wait 16384 internal periods before first activation.
// [R12] Register access keeps working during Sleep.
// [R13] Entering Sleep clears results, errors, interrupt.
// [R14] Host configures while asleep; recommended only.
// [R15] Normal mode converts active channels continuously.
// [R16] Shutdown pin high: no conversions, defaults.
// [R17] Shutdown clears errors, drives interrupt high, ignores bus.
// [R18] Soft reset stops conversion, defaults; reads zero.
// [R19] Host reads results only in Normal mode.
// [R20] 7-bit address, 8-bit pointer, 16-bit registers.
// [R21] Target never stretches the clock.
// [R22] Address 0x2A low, 0x2B high select.
// [R23] High word read loads both words from shadow.
// [R24] Host never ends a transaction early.
// [R25] Address select sampled leaving Shutdown, then held.
`timescale 1ns/1ps
`include "icmc_defines.vh"
module icmc_mode_ctrl #(
	parameter [19:0] WAKE_TICKS = `ICMC_WAKE_PERIODS,
	parameter [15:0] MFR_ID     = 16'hA5C3, // Arbitrary value.
	parameter [15:0] DEV_ID     = 16'h0F1E  // Arbitrary value.
) (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst,
	// Device pins
	input  wire        shutdown_pin,
	input  wire        addr_sel_pin,
	input  wire        external_ref_clock_in,
	output reg         interrupt_out_n,
	// Two-wire target pins
	input  wire        scl_in,
	input  wire        sda_in,
	output wire        sda_out,
	output reg         sda_oe,
	// Front end control
	output reg  [1:0]  fe_channel,
	output reg         fe_activate,
	output reg         fe_measure,
	output reg  [3:0]  fe_fin_div,
	output reg  [4:0]  drive_current_code,
	output reg         auto_drive_select,
	// Front end results
	input  wire [27:0] fe_result,
	input  wire        fe_err_under,
	input  wire        fe_err_over,
	input  wire        fe_err_nosc,
	input  wire        fe_err_amp
);

	localparam [2:0] I_IDLE = 3'd0, I_RX = 3'd1, I_ACK = 3'd2, I_TX = 3'd3, I_HACK = 3'd4;
	localparam [1:0] Q_SLEEP = 2'd0, Q_WAKE = 2'd1, Q_SETTLE = 2'd2, Q_CONV = 2'd3;
	localparam [31:0] DIV_W = `ICMC_INT_DIV - 1;
	localparam [2:0] INT_DIV_M1 = DIV_W[2:0];
	localparam [7:0] A_RC = `ICMC_REG_RCOUNT0, A_OF = `ICMC_REG_OFFSET0, A_ST = `ICMC_REG_SETTLE0;
	localparam [7:0] A_CD = `ICMC_REG_CLKDIV0, A_DRV = `ICMC_REG_DRIVE0;

	integer i;

	// Configuration registers.
	reg [15:0] rcount_q [0:3];
	reg [15:0] offset_q [0:3];
	reg [15:0] settle_q [0:3];
	reg [15:0] clkdiv_q [0:3];
	reg [15:0] drive_q  [0:3];
	reg [15:0] errcfg_q, cfg_q, mux_q;
	reg        soft_rst_q;
	// Results and status.
	reg [27:0] sh_data_q [0:3];
	reg [3:0]  sh_flag_q [0:3];
	reg [15:0] vis_lsb_q [0:3];
	reg [3:0]  unread_q;
	reg        drdy_q, st_amp_q, st_wd_q;
	// Two-wire target.
	reg        scl_q, scl_p, sda_q, sda_p;
	reg [2:0]  ist_q;
	reg [3:0]  bit_cnt_q;
	reg [1:0]  byte_idx_q;
	reg [7:0]  rx_sh_q, tx_sh_q, tx_lo_q, ptr_q, wr_hi_q;
	reg        rd_mode_q, tx_second_q;
	reg [6:0]  my_addr_q;
	reg        addr_init_q;
	reg [15:0] rd_word;
	// Sequencer and reference timing.
	reg [1:0]  seq_q, ch_q;
	reg [2:0]  int_cnt_q;
	reg        int_tick_q, ext_q, ext_p, fref_tick_q;
	reg [9:0]  div_cnt_q;
	reg        tmr_load;
	reg [19:0] tmr_val;
	wire       tmr_done;

	wire clr_cfg    = shutdown_pin | soft_rst_q;
	wire sleep_en   = cfg_q[`ICMC_CFG_SLEEP];
	wire multi      = mux_q[`ICMC_MUX_AUTOSCAN];
	wire [1:0] act  = cfg_q[`ICMC_CFG_CHAN_HI:`ICMC_CFG_CHAN_LO];
	wire [1:0] seqf = mux_q[`ICMC_MUX_SEQ_HI:`ICMC_MUX_SEQ_LO];
	wire [1:0] last_ch = (seqf == 2'b11) ? 2'd3 : seqf + 2'd1;
	wire scl_rise = scl_q & ~scl_p;
	wire scl_fall = ~scl_q & scl_p;
	wire i_start  = scl_q & scl_p & sda_p & ~sda_q;
	wire i_stop   = scl_q & scl_p & ~sda_p & sda_q;
	wire [7:0] rx_byte = {rx_sh_q[6:0], sda_q};
	wire rd_load = (ist_q == I_ACK && scl_fall && rd_mode_q && byte_idx_q == 2'd0) ||
	               (ist_q == I_HACK && scl_fall && tx_second_q);
	wire wr_commit = ist_q == I_RX && scl_fall && bit_cnt_q == 4'd8 && byte_idx_q == 2'd3;
	wire [15:0] wr_data = {wr_hi_q, rx_sh_q};
	wire [1:0] pc = ptr_q[1:0];
	wire [1:0] di = ptr_q[1:0] + 2'd2;
	wire in_drv = (ptr_q >= A_DRV) && (ptr_q <= A_DRV + 8'd3);
	wire msb_rd = rd_load && ptr_q[7:3] == 5'h00 && !ptr_q[0];
	wire stat_rd = rd_load && ptr_q == `ICMC_REG_STATUS;
	wire conv_done = (seq_q == Q_CONV) && tmr_done;
	wire src_tick = cfg_q[`ICMC_CFG_REF_SRC] ? (ext_q & ~ext_p) : int_tick_q; // [R6]

	// Open-drain data line, only pulled low; SCL is never driven. [R21]
	assign sda_out = 1'b0;

	// Configuration writes; shutdown and soft reset force defaults. [R16] [R18]
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (i = 0; i < 4; i = i + 1) begin
				rcount_q[i] <= `ICMC_DEF_RCOUNT;
				offset_q[i] <= `ICMC_DEF_ZERO;
				settle_q[i] <= `ICMC_DEF_ZERO;
				clkdiv_q[i] <= `ICMC_DEF_ZERO;
				drive_q[i]  <= `ICMC_DEF_ZERO;
			end
			errcfg_q   <= `ICMC_DEF_ZERO;
			cfg_q      <= `ICMC_DEF_CONFIG; // [R9]
			mux_q      <= `ICMC_DEF_MUXCFG;
			soft_rst_q <= 1'b0;
		end else if (clr_cfg) begin
			for (i = 0; i < 4; i = i + 1) begin
				rcount_q[i] <= `ICMC_DEF_RCOUNT;
				offset_q[i] <= `ICMC_DEF_ZERO;
				settle_q[i] <= `ICMC_DEF_ZERO;
				clkdiv_q[i] <= `ICMC_DEF_ZERO;
				drive_q[i]  <= `ICMC_DEF_ZERO;
			end
			errcfg_q   <= `ICMC_DEF_ZERO;
			cfg_q      <= `ICMC_DEF_CONFIG;
			mux_q      <= `ICMC_DEF_MUXCFG;
			soft_rst_q <= 1'b0;
		end else begin
			soft_rst_q <= wr_commit && ptr_q == `ICMC_REG_RESET && wr_data[`ICMC_RESET_BIT]; // [R18]
			if (wr_commit) begin
				if (ptr_q[7:2] == A_RC[7:2]) rcount_q[pc] <= wr_data; // [R3]
				if (ptr_q[7:2] == A_OF[7:2]) offset_q[pc] <= wr_data;
				if (ptr_q[7:2] == A_ST[7:2]) settle_q[pc] <= wr_data; // [R4]
				if (ptr_q[7:2] == A_CD[7:2]) clkdiv_q[pc] <= wr_data; // [R5]
				if (in_drv) drive_q[di] <= wr_data; // [R7]
				if (ptr_q == `ICMC_REG_ERRCFG) errcfg_q <= wr_data;
				if (ptr_q == `ICMC_REG_CONFIG) cfg_q <= wr_data; // [R10]
				if (ptr_q == `ICMC_REG_MUXCFG) mux_q <= wr_data;
			end
		end
	end

	// Read data at the pointer; the high result word comes from the shadow.
	always @* begin
		rd_word = 16'h0000;
		if (ptr_q[7:3] == 5'h00)
			rd_word = ptr_q[0] ? vis_lsb_q[ptr_q[2:1]] : {sh_flag_q[ptr_q[2:1]], sh_data_q[ptr_q[2:1]][27:16]}; // [R23]
		else if (ptr_q[7:2] == A_RC[7:2])
			rd_word = rcount_q[pc];
		else if (ptr_q[7:2] == A_OF[7:2])
			rd_word = offset_q[pc];
		else if (ptr_q[7:2] == A_ST[7:2])
			rd_word = settle_q[pc];
		else if (ptr_q[7:2] == A_CD[7:2])
			rd_word = clkdiv_q[pc];
		else if (in_drv)
			rd_word = drive_q[di];
		else if (ptr_q == `ICMC_REG_STATUS)
			rd_word = {3'b000, st_amp_q, st_wd_q, 4'h0, drdy_q, 2'b00, unread_q}; // [R8]
		else if (ptr_q == `ICMC_REG_ERRCFG)
			rd_word = errcfg_q;
		else if (ptr_q == `ICMC_REG_CONFIG)
			rd_word = cfg_q;
		else if (ptr_q == `ICMC_REG_MUXCFG)
			rd_word = mux_q;
		else if (ptr_q == `ICMC_REG_MFR_ID)
			rd_word = MFR_ID;
		else if (ptr_q == `ICMC_REG_DEV_ID)
			rd_word = DEV_ID;
	end

	// Results, flags and status; a new event beats a read clear.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			for (i = 0; i < 4; i = i + 1) begin
				sh_data_q[i] <= 28'h0000000;
				sh_flag_q[i] <= 4'h0;
				vis_lsb_q[i] <= 16'h0000;
			end
			unread_q <= 4'h0;
			drdy_q   <= 1'b0;
			st_amp_q <= 1'b0;
			st_wd_q  <= 1'b0;
		end else if (clr_cfg || sleep_en) begin
			for (i = 0; i < 4; i = i + 1) begin
				sh_data_q[i] <= 28'h0000000; // [R13]
				sh_flag_q[i] <= 4'h0; // [R17]
				vis_lsb_q[i] <= 16'h0000;
			end
			unread_q <= 4'h0;
			drdy_q   <= 1'b0;
			st_amp_q <= 1'b0;
			st_wd_q  <= 1'b0;
		end else begin
			if (msb_rd) begin
				vis_lsb_q[ptr_q[2:1]] <= sh_data_q[ptr_q[2:1]][15:0]; // [R23]
				sh_flag_q[ptr_q[2:1]] <= 4'h0;
				unread_q[ptr_q[2:1]]  <= 1'b0;
			end
			if (stat_rd) begin
				drdy_q   <= 1'b0;
				st_amp_q <= 1'b0;
				st_wd_q  <= 1'b0;
			end
			if (conv_done) begin
				sh_data_q[ch_q] <= fe_result;
				sh_flag_q[ch_q] <= (msb_rd && ptr_q[2:1] == ch_q ? 4'h0 : sh_flag_q[ch_q]) |
				                   {fe_err_under, fe_err_over, fe_err_nosc, fe_err_amp}; // [R8]
				unread_q[ch_q] <= 1'b1;
				if (fe_err_amp) st_amp_q <= 1'b1;
				if (fe_err_nosc) st_wd_q <= 1'b1;
				if (!multi || ch_q == last_ch) drdy_q <= 1'b1; // [R2]
			end
		end
	end

	// Interrupt line, high in shutdown and while no data is pending.
	always @(posedge core_clk or posedge rst) begin
		if (rst)
			interrupt_out_n <= 1'b1;
		else if (shutdown_pin)
			interrupt_out_n <= 1'b1; // [R17]
		else
			interrupt_out_n <= ~(drdy_q & errcfg_q[`ICMC_ERRCFG_DRDY_INT]); // [R2] [R13]
	end

	// Target address caught at power-up and in shutdown.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			my_addr_q   <= `ICMC_I2C_ADDR_LOW;
			addr_init_q <= 1'b0;
		end else begin
			addr_init_q <= 1'b1;
			if (shutdown_pin || !addr_init_q)
				my_addr_q <= addr_sel_pin ? `ICMC_I2C_ADDR_HIGH : `ICMC_I2C_ADDR_LOW; // [R22] [R25]
		end
	end

	// Two-wire target: address, pointer, then words high byte first.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			scl_q <= 1'b1; scl_p <= 1'b1; sda_q <= 1'b1; sda_p <= 1'b1;
			ist_q <= I_IDLE; bit_cnt_q <= 4'h0; byte_idx_q <= 2'd0;
			rx_sh_q <= 8'h00; tx_sh_q <= 8'h00; tx_lo_q <= 8'h00;
			ptr_q <= 8'h00; wr_hi_q <= 8'h00;
			rd_mode_q <= 1'b0; tx_second_q <= 1'b0; sda_oe <= 1'b0;
		end else begin
			scl_q <= scl_in; scl_p <= scl_q;
			sda_q <= sda_in; sda_p <= sda_q;
			if (shutdown_pin) begin
				ist_q  <= I_IDLE; // [R17]
				sda_oe <= 1'b0;
			end else if (i_start) begin
				ist_q <= I_RX; bit_cnt_q <= 4'h0; byte_idx_q <= 2'd0; sda_oe <= 1'b0;
			end else if (i_stop) begin
				ist_q <= I_IDLE; sda_oe <= 1'b0;
			end else begin
				case (ist_q)
				I_RX: begin
					if (scl_rise) begin
						rx_sh_q   <= rx_byte;
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (scl_fall && bit_cnt_q == 4'd8) begin
						bit_cnt_q <= 4'h0;
						if (byte_idx_q == 2'd0 && rx_sh_q[7:1] != my_addr_q) begin
							ist_q <= I_IDLE; // [R22]
						end else begin
							ist_q  <= I_ACK; // [R12] [R20]
							sda_oe <= 1'b1;
							if (byte_idx_q == 2'd0) rd_mode_q <= rx_sh_q[0];
							if (byte_idx_q == 2'd1) ptr_q <= rx_sh_q;
							if (byte_idx_q == 2'd2) wr_hi_q <= rx_sh_q;
							if (wr_commit) ptr_q <= ptr_q + 8'h01;
						end
					end
				end
				I_ACK: begin
					if (scl_fall) begin
						if (rd_load) begin
							ist_q <= I_TX; tx_second_q <= 1'b0;
							tx_sh_q <= {rd_word[14:8], 1'b0}; tx_lo_q <= rd_word[7:0];
							sda_oe <= ~rd_word[15]; bit_cnt_q <= 4'h1;
							ptr_q <= ptr_q + 8'h01;
						end else begin
							ist_q <= I_RX; sda_oe <= 1'b0;
							byte_idx_q <= (byte_idx_q == 2'd3) ? 2'd2 : byte_idx_q + 2'd1;
						end
					end
				end
				I_TX: begin
					if (scl_fall) begin
						if (bit_cnt_q == 4'd8) begin
							ist_q <= I_HACK; sda_oe <= 1'b0;
						end else begin
							sda_oe    <= ~tx_sh_q[7];
							tx_sh_q   <= {tx_sh_q[6:0], 1'b0};
							bit_cnt_q <= bit_cnt_q + 4'h1;
						end
					end
				end
				I_HACK: begin
					if (scl_rise && sda_q) begin
						ist_q <= I_IDLE;
					end else if (scl_fall) begin
						ist_q <= I_TX; bit_cnt_q <= 4'h1;
						if (tx_second_q) begin
							tx_second_q <= 1'b0;
							tx_sh_q <= {rd_word[14:8], 1'b0}; tx_lo_q <= rd_word[7:0];
							sda_oe <= ~rd_word[15]; ptr_q <= ptr_q + 8'h01;
						end else begin
							tx_second_q <= 1'b1;
							tx_sh_q <= {tx_lo_q[6:0], 1'b0};
							sda_oe <= ~tx_lo_q[7];
						end
					end
				end
				default: begin
					ist_q  <= I_IDLE;
					sda_oe <= 1'b0;
				end
				endcase
			end
		end
	end

	// Reference ticks: internal rate or external clock edges, then the per-channel divider.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			int_cnt_q <= 3'd0; int_tick_q <= 1'b0;
			ext_q <= 1'b0; ext_p <= 1'b0;
			div_cnt_q <= 10'd0; fref_tick_q <= 1'b0;
		end else begin
			ext_q <= external_ref_clock_in;
			ext_p <= ext_q;
			int_tick_q  <= int_cnt_q == INT_DIV_M1;
			int_cnt_q   <= (int_cnt_q == INT_DIV_M1) ? 3'd0 : int_cnt_q + 3'd1;
			fref_tick_q <= 1'b0;
			if (seq_q == Q_SLEEP || seq_q == Q_WAKE) begin
				div_cnt_q <= 10'd0;
			end else if (src_tick) begin
				if (div_cnt_q + 10'd1 >= clkdiv_q[ch_q][9:0]) begin
					div_cnt_q   <= 10'd0; // [R5]
					fref_tick_q <= 1'b1;
				end else begin
					div_cnt_q <= div_cnt_q + 10'd1;
				end
			end
		end
	end

	// Sequencer: sleep, wake delay, then settle and convert per channel.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			seq_q <= Q_SLEEP; ch_q <= 2'd0;
			tmr_load <= 1'b0; tmr_val <= 20'h00000;
		end else begin
			tmr_load <= 1'b0;
			if (clr_cfg || sleep_en) begin
				seq_q <= Q_SLEEP; // [R9] [R10] [R16] [R18]
			end else begin
				case (seq_q)
				Q_SLEEP: begin
					seq_q <= Q_WAKE; tmr_load <= 1'b1; tmr_val <= WAKE_TICKS; // [R11]
				end
				Q_WAKE: if (tmr_done) begin
					seq_q <= Q_SETTLE; tmr_load <= 1'b1;
					ch_q <= multi ? 2'd0 : act;
					tmr_val <= {settle_q[multi ? 2'd0 : act], 4'h0}; // [R4]
				end
				Q_SETTLE: if (tmr_done) begin
					seq_q <= Q_CONV; tmr_load <= 1'b1;
					tmr_val <= {rcount_q[ch_q], 4'h0}; // [R3]
				end
				Q_CONV: if (tmr_done) begin
					seq_q <= Q_SETTLE; tmr_load <= 1'b1; // [R15]
					ch_q <= !multi ? act : (ch_q == last_ch ? 2'd0 : ch_q + 2'd1); // [R1]
					tmr_val <= {settle_q[!multi ? act : (ch_q == last_ch ? 2'd0 : ch_q + 2'd1)], 4'h0};
				end
				default: seq_q <= Q_SLEEP;
				endcase
			end
		end
	end

	// Wake, settle and convert timer.
	icmc_timer u_timer (
		.core_clk (core_clk),
		.rst      (rst),
		.load     (tmr_load),
		.load_val (tmr_val),
		.tick     (seq_q == Q_WAKE ? int_tick_q : fref_tick_q),
		.done     (tmr_done)
	);

	// Front end steering from the channel in work.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fe_channel <= 2'd0; fe_activate <= 1'b0; fe_measure <= 1'b0;
			fe_fin_div <= 4'h0; drive_current_code <= 5'h00; auto_drive_select <= 1'b0;
		end else begin
			fe_channel  <= ch_q;
			fe_activate <= seq_q == Q_SETTLE || seq_q == Q_CONV;
			fe_measure  <= seq_q == Q_CONV;
			fe_fin_div  <= clkdiv_q[ch_q][15:12]; // [R5]
			drive_current_code <= drive_q[ch_q][15:11]; // [R7]
			auto_drive_select  <= cfg_q[`ICMC_CFG_AUTO_DRV]; // [R7]
		end
	end

endmodule // icmc_mode_ctrl

// File: hdl/icmc_defines.vh
// Purpose: Constants for the inductive converter mode control block.
// Assumes: 250 MHz core clock; 16-bit registers, 8-bit pointer.
// Notes:   Offsets are pointer values; fields are bit positions.
`ifndef ICMC_DEFINES_VH
`define ICMC_DEFINES_VH

// Register pointer values.
`define ICMC_REG_RCOUNT0     8'h08
`define ICMC_REG_OFFSET0     8'h0C
`define ICMC_REG_SETTLE0     8'h10
`define ICMC_REG_CLKDIV0     8'h14
`define ICMC_REG_STATUS      8'h18
`define ICMC_REG_ERRCFG      8'h19
`define ICMC_REG_CONFIG      8'h1A
`define ICMC_REG_MUXCFG      8'h1B
`define ICMC_REG_RESET       8'h1C
`define ICMC_REG_DRIVE0      8'h1E
`define ICMC_REG_MFR_ID      8'h7E
`define ICMC_REG_DEV_ID      8'h7F

// Reset values.
`define ICMC_DEF_ZERO        16'h0000
`define ICMC_DEF_RCOUNT      16'h0080
`define ICMC_DEF_CONFIG      16'h2801
`define ICMC_DEF_MUXCFG      16'h020F

// Field positions.
`define ICMC_CFG_CHAN_HI     15
`define ICMC_CFG_CHAN_LO     14
`define ICMC_CFG_SLEEP       13
`define ICMC_CFG_AUTO_DRV    12
`define ICMC_CFG_REF_SRC     9
`define ICMC_MUX_AUTOSCAN    15
`define ICMC_MUX_SEQ_HI      14
`define ICMC_MUX_SEQ_LO      13
`define ICMC_ERRCFG_DRDY_INT 0
`define ICMC_RESET_BIT       15

// Target addresses for the two address select levels.
`define ICMC_I2C_ADDR_LOW    7'h2A
`define ICMC_I2C_ADDR_HIGH   7'h2B

// Timing: internal tick derived from the core clock.
`define ICMC_CORE_MHZ        250
`define ICMC_INT_OSC_MHZ     43
`define ICMC_INT_DIV         (`ICMC_CORE_MHZ / `ICMC_INT_OSC_MHZ)
`define ICMC_WAKE_PERIODS    20'd16384
`define ICMC_CNT_SHIFT       4

`endif

// File: hdl/icmc_timer.v
// Purpose: Down-counting timer advanced by a tick enable.
// Assumes: load and tick come from the same clock domain.
// Notes:   done pulses one cycle after the last counted tick.
`timescale 1ns/1ps
module icmc_timer (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst,
	// Control
	input  wire        load,
	input  wire [19:0] load_val,
	input  wire        tick,
	// Result
	output reg         done
);

	reg [19:0] cnt_q;
	reg        run_q;

	// A load restarts the count; a zero load ends on the first tick.
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 20'h00000;
			run_q <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (load) begin
				cnt_q <= load_val;
				run_q <= 1'b1;
			end else if (run_q && tick) begin
				if (cnt_q <= 20'h00001) begin
					run_q <= 1'b0;
					done  <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 20'h00001;
				end
			end
		end
	end

endmodule // icmc_timer

// File: tb/icmc_mode_ctrl_monitor.sv
// Purpose: Port checker for the mode control block.
// Assumes: One clock; rst asynchronous, active high.
// Notes:   Bound below; sees the pins only.
`timescale 1ns/1ps
module icmc_mode_ctrl_monitor #(
	parameter [19:0] WAKE_TICKS = 20'h04000
) (
	// Clock and reset
	input wire       core_clk,
	input wire       rst,
	// Pins watched
	input wire       shutdown_pin,
	input wire       interrupt_out_n,
	input wire       scl_in,
	input wire       sda_oe,
	input wire [1:0] fe_channel,
	input wire       fe_activate,
	input wire       fe_measure,
	input wire [3:0] fe_fin_div,
	input wire [4:0] drive_current_code,
	input wire       auto_drive_select
);
	localparam [31:0] WAKE_MIN = (WAKE_TICKS - 20'h1) * 32'h5;
	reg        fresh_q;
	reg [31:0] idle_q;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Counts cycles from reset or shutdown to the first activation.
	always @(posedge core_clk or posedge rst) begin
		if (rst || shutdown_pin) begin
			fresh_q <= 1'b1;
			idle_q  <= 32'h0;
		end else begin
			if (fe_activate)
				fresh_q <= 1'b0;
			if (fresh_q)
				idle_q <= idle_q + 32'h1;
		end
	end
	// Shutdown held long enough for its effects to land.
	sequence s_shut_held;
		shutdown_pin [*3];
	endsequence
	sequence s_meas_run;
		fe_measure ##1 fe_measure;
	endsequence
	a_shut_int_high: assert property (s_shut_held |-> interrupt_out_n)
		else $error("interrupt low in shutdown");
	a_shut_no_conv: assert property (s_shut_held |-> !fe_activate && !fe_measure)
		else $error("sensor active in shutdown");
	a_shut_bus_quiet: assert property (s_shut_held |-> !sda_oe)
		else $error("bus answered in shutdown");
	a_shut_defaults: assert property (s_shut_held |-> drive_current_code == 5'h0 && !auto_drive_select && fe_fin_div == 4'h0)
		else $error("settings not default in shutdown");
	a_wake_wait: assert property ($rose(fe_activate) && fresh_q |-> idle_q >= WAKE_MIN)
		else $error("activation before wake wait");
	a_int_after_conv: assert property ($fell(interrupt_out_n) |-> $past(fe_measure) || $past(fe_measure, 2) || $past(fe_measure, 3))
		else $error("interrupt without conversion");
	a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
		else $error("data pulled while clock high");
	a_meas_needs_act: assert property (fe_measure |-> fe_activate)
		else $error("measure without activation");
	a_meas_chan_stable: assert property (s_meas_run |-> $stable(fe_channel))
		else $error("channel changed in conversion");
endmodule // icmc_mode_ctrl_monitor

bind icmc_mode_ctrl icmc_mode_ctrl_monitor #(.WAKE_TICKS(WAKE_TICKS)) mon_u (
	.core_clk(core_clk), .rst(rst), .shutdown_pin(shutdown_pin), .interrupt_out_n(interrupt_out_n),
	.scl_in(scl_in), .sda_oe(sda_oe), .fe_channel(fe_channel), .fe_activate(fe_activate),
	.fe_measure(fe_measure), .fe_fin_div(fe_fin_div), .drive_current_code(drive_current_code),
	.auto_drive_select(auto_drive_select));

// File: tb/icmc_i2c_host.sv
// Purpose: Two-wire bus host model.
// Assumes: SDA pulled up; SCL push-pull.
// Notes:   Reports address ack and any word read.
`timescale 1ns/1ps
module icmc_i2c_host #(
	parameter int Q = 8
) (
	// Clock
	input  wire logic   core_clk,
	// Bus wires
	output logic        scl,
	output logic        sda_low,
	input  wire logic   sda,
	// Results to the bench
	output logic        res_stb,
	output logic [15:0] res_val
);
	logic [7:0] hi_b, lo_b;
	logic       ack;
	// Both lines are released at time zero.
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
		res_stb = 1'b0;
		res_val = 16'h0000;
	end
	task automatic wq();
		repeat (Q) @(posedge core_clk);
	endtask
	// Data set while SCL low, sampled mid high; no wait on SCL.
	task automatic bit_io(input logic b, output logic s);
		sda_low <= !b;
		wq();
		scl <= 1'b1;
		wq();
		s = sda;
		wq();
		scl <= 1'b0;
		wq();
	endtask
	task automatic start();
		sda_low <= 1'b0;
		wq();
		scl <= 1'b1;
		wq();
		sda_low <= 1'b1;
		wq();
		scl <= 1'b0;
		wq();
	endtask
	task automatic stop();
		sda_low <= 1'b1;
		wq();
		scl <= 1'b1;
		wq();
		sda_low <= 1'b0;
		wq();
	endtask
	// Eight bits MSB first, then the ack slot; never cut short.
	task automatic byte_w(input [7:0] b, output logic a);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], s);
		bit_io(1'b1, s);
		a = !s;
	endtask
	task automatic byte_r(input logic last, output [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			b[i] = s;
		end
		bit_io(last, s);
	endtask
	task automatic emit(input [15:0] v);
		res_val <= v;
		res_stb <= 1'b1;
		@(posedge core_clk);
		res_stb <= 1'b0;
	endtask
	// Write: address, pointer, high byte, low byte.
	task automatic wr(input [6:0] a, input [7:0] p, input [15:0] v);
		start();
		byte_w({a, 1'b0}, ack);
		emit({15'h0, ack});
		if (ack) begin
			byte_w(p, ack);
			byte_w(v[15:8], ack);
			byte_w(v[7:0], ack);
		end
		stop();
	endtask
	// Read: pointer, repeated start, two bytes, NACK.
	task automatic rd(input [6:0] a, input [7:0] p);
		start();
		byte_w({a, 1'b0}, ack);
		emit({15'h0, ack});
		if (ack) begin
			byte_w(p, ack);
			start();
			byte_w({a, 1'b1}, ack);
			byte_r(1'b0, hi_b);
			byte_r(1'b1, lo_b);
			emit({hi_b, lo_b});
		end
		stop();
	endtask
endmodule // icmc_i2c_host

// File: tb/tb.sv
// Purpose: Self-checking bench for the mode control block.
// Assumes: The host model drives SCL and SDA.
// Notes:   Expectations queue up and are compared in order.
`timescale 1ns/1ps
`include "icmc_defines.vh"
`define CHK(got, exp) begin checks = checks + 1; if ((got) !== (exp)) begin err_total = err_total + 1; \
	$display("BAD %0t got %h exp %h", $time, got, exp); end end
module tb;
	localparam [19:0] WAKE = 20'h00010;
	localparam [15:0] MFR = 16'h1357; // Arbitrary value.
	localparam [15:0] DEV = 16'h2468; // Arbitrary value.
	localparam [6:0]  AL = `ICMC_I2C_ADDR_LOW;
	localparam [6:0]  AH = `ICMC_I2C_ADDR_HIGH;
	localparam [15:0] M_INT = 16'h2000, M_ACT = 16'h1000, M_AUTO = 16'h0800, M_DRV = 16'h07C0, M_FIN = 16'h003C;
	// Stimulus and observation signals.
	logic        core_clk = 0, rst = 1, shutdown_pin = 0, addr_sel_pin = 0, ext_clk = 0, ext_run = 0, pin_stb = 0;
	logic [27:0] fe_result = 0;
	logic [3:0]  fe_err = 0;
	logic [1:0]  seen = 0, ext_div = 0;
	logic [15:0] pin_val = 0, exp_v, got_v, q[$];
	integer      err_total = 0, checks = 0, seed = 32'h4CA2, n;
	wire         scl, sda, sda_low, sda_out, sda_oe, res_stb, interrupt_out_n, fe_activate, fe_measure, auto_drv;
	wire [15:0]  res_val, pins;
	wire [1:0]   fe_channel;
	wire [3:0]   fe_fin_div;
	wire [4:0]   drive_code;
	// Open-drain data line with pull-up.
	assign sda = !(sda_low || (sda_oe && !sda_out));
	assign pins = {seen, interrupt_out_n, fe_activate, auto_drv, drive_code, fe_fin_div, fe_channel};
	always #2 core_clk = !core_clk;
	icmc_mode_ctrl #(.WAKE_TICKS(WAKE), .MFR_ID(MFR), .DEV_ID(DEV)) dut_u (
		.core_clk(core_clk), .rst(rst), .shutdown_pin(shutdown_pin), .addr_sel_pin(addr_sel_pin),
		.external_ref_clock_in(ext_clk), .interrupt_out_n(interrupt_out_n), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .fe_channel(fe_channel), .fe_activate(fe_activate),
		.fe_measure(fe_measure), .fe_fin_div(fe_fin_div), .drive_current_code(drive_code),
		.auto_drive_select(auto_drv), .fe_result(fe_result), .fe_err_under(fe_err[3]),
		.fe_err_over(fe_err[2]), .fe_err_nosc(fe_err[1]), .fe_err_amp(fe_err[0]));
	icmc_i2c_host host_u (.core_clk(core_clk), .scl(scl), .sda_low(sda_low), .sda(sda),
		.res_stb(res_stb), .res_val(res_val));
	// External reference at one eighth of core rate; records channels 0 and 1 measured since activation.
	always @(posedge core_clk) begin
		ext_div <= ext_div + 2'h1;
		if (ext_run && ext_div == 2'h3)
			ext_clk <= !ext_clk;
		if (!fe_activate)
			seen <= 2'b00;
		else if (fe_measure && !fe_channel[1])
			seen[fe_channel[0]] <= 1'b1;
	end
	// Compares the oldest expectation with each result.
	always @(posedge core_clk) begin
		if (res_stb || pin_stb) begin
			exp_v = q.pop_front();
			got_v = res_stb ? res_val : pin_val;
			`CHK(got_v, exp_v)
		end
	end
	task automatic pin(input [15:0] e, input [15:0] m);
		q.push_back(e);
		@(negedge core_clk);
		pin_val = pins & m;
		@(posedge core_clk);
		pin_stb <= 1'b1;
		@(posedge core_clk);
		pin_stb <= 1'b0;
	endtask
	task automatic rd(input [6:0] a, input [7:0] p, input [15:0] e, input logic ack);
		q.push_back({15'h0, ack});
		if (ack)
			q.push_back(e);
		host_u.rd(a, p);
	endtask
	task automatic wr(input [7:0] p, input [15:0] v);
		q.push_back(16'h0001);
		host_u.wr(AL, p, v);
	endtask
	task automatic wait_int(input integer lim);
		n = 0;
		while (interrupt_out_n !== 1'b0 && n < lim) begin
			@(posedge core_clk);
			n = n + 1;
		end
	endtask
	task automatic give_verdict;
		err_total = err_total + q.size();
		if (err_total == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Defaults, conversion, sleep, reference, soft reset, scan, shutdown.
	initial begin
		fe_result <= 28'($random(seed));
		fe_err <= 4'($random(seed));
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		rd(AL, `ICMC_REG_CONFIG, `ICMC_DEF_CONFIG, 1'b1);
		rd(AL, `ICMC_REG_MUXCFG, `ICMC_DEF_MUXCFG, 1'b1);
		rd(AL, `ICMC_REG_RCOUNT0, `ICMC_DEF_RCOUNT, 1'b1);
		rd(AL, `ICMC_REG_MFR_ID, MFR, 1'b1);
		rd(AL, 8'h40, 16'h0000, 1'b1);
		rd(AH, `ICMC_REG_CONFIG, 16'h0000, 1'b0);
		pin(16'h0000, M_ACT);
		wr(`ICMC_REG_SETTLE0, 16'h0001);
		wr(`ICMC_REG_RCOUNT0, 16'h0002);
		wr(`ICMC_REG_CLKDIV0, 16'h3001);
		wr(`ICMC_REG_DRIVE0, 16'hA800);
		wr(`ICMC_REG_ERRCFG, 16'h0001);
		pin(16'h054C, M_DRV | M_FIN);
		wr(`ICMC_REG_CONFIG, 16'h1801);
		wait_int(3000);
		pin(16'h0800, M_INT | M_AUTO | 16'h0003);
		rd(AL, 8'h00, {fe_err, fe_result[27:16]}, 1'b1);
		rd(AL, 8'h01, fe_result[15:0], 1'b1);
		wr(`ICMC_REG_CONFIG, `ICMC_DEF_CONFIG);
		pin(M_INT, M_INT | M_ACT);
		wr(`ICMC_REG_CONFIG, 16'h0A01);
		repeat (1500) @(posedge core_clk);
		pin(M_INT, M_INT);
		ext_run <= 1'b1;
		wait_int(6000);
		pin(16'h0000, M_INT);
		wr(`ICMC_REG_RESET, 16'h8000);
		rd(AL, `ICMC_REG_RESET, 16'h0000, 1'b1);
		rd(AL, `ICMC_REG_CONFIG, `ICMC_DEF_CONFIG, 1'b1);
		pin(M_INT, M_INT | M_ACT);
		ext_run <= 1'b0;
		wr(`ICMC_REG_ERRCFG, 16'h0001);
		wr(`ICMC_REG_RCOUNT0, 16'h0004);
		wr(`ICMC_REG_RCOUNT0 + 8'h01, 16'h0004);
		wr(`ICMC_REG_MUXCFG, 16'h820F);
		wr(`ICMC_REG_CONFIG, 16'h0801);
		wait_int(3000);
		pin(16'hC000, M_INT | 16'hC000);
		shutdown_pin <= 1'b1;
		addr_sel_pin <= 1'b1;
		repeat (4) @(posedge core_clk);
		pin(M_INT, M_INT | M_ACT | M_DRV | M_AUTO);
		rd(AH, `ICMC_REG_CONFIG, 16'h0000, 1'b0);
		shutdown_pin <= 1'b0;
		repeat (4) @(posedge core_clk);
		rd(AH, `ICMC_REG_CONFIG, `ICMC_DEF_CONFIG, 1'b1);
		rd(AL, `ICMC_REG_CONFIG, 16'h0000, 1'b0);
		give_verdict;
	end
	// A run takes about 36000 cycles; a hang stops here.
	initial begin
		repeat (100000) @(posedge core_clk);
		err_total = err_total + 1;
		give_verdict;
	end
endmodule // tb
